/* design/tcsc_pkg.sv */
// Shared constants for the timer compare status and control block
package tcsc_pkg;

	// Register byte addresses on the AXI4-Lite slave
	localparam logic [7:0] TCSC_ADDR_CH0 = 8'h00;
	localparam logic [7:0] TCSC_ADDR_CH1 = 8'h04;
	localparam logic [7:0] TCSC_ADDR_PINS = 8'h08;
	localparam int TCSC_ADDR_W = 8;
	localparam int TCSC_WORD_LSB = 2;

	// Field positions inside a compare status and control register
	localparam int TCSC_BIT_MATCH_B = 7;
	localparam int TCSC_BIT_MATCH_A = 6;
	localparam int TCSC_BIT_WRAP = 5;
	localparam int TCSC_BIT_ADC_TRIGGER_ENABLE = 4;
	localparam int TCSC_OSB_HI = 3;
	localparam int TCSC_OSB_LO = 2;
	localparam int TCSC_OSA_HI = 1;
	localparam int TCSC_OSA_LO = 0;

	// Flag vector indices
	localparam int TCSC_F_WRAP = 0;
	localparam int TCSC_F_A = 1;
	localparam int TCSC_F_B = 2;
	localparam int TCSC_NFLAGS = 3;

	// Reset values
	localparam logic [2:0] TCSC_FLAGS_RST = 3'h0;
	localparam logic [1:0] TCSC_OSEL_RST = 2'h0;
	localparam logic TCSC_ADC_TRIGGER_ENABLE_RST = 1'b0;
	localparam logic TCSC_PIN_RST = 1'b0;
	localparam logic TCSC_RSVD_READ = 1'b1;

	// Counter limit at which the next update wraps to zero
	localparam logic [7:0] TCSC_COUNT_MAX = 8'hFF;

	// Pin actions; the numeric order is also the priority order
	localparam logic [1:0] TCSC_ACT_KEEP = 2'h0;
	localparam logic [1:0] TCSC_ACT_DRIVE0 = 2'h1;
	localparam logic [1:0] TCSC_ACT_DRIVE1 = 2'h2;
	localparam logic [1:0] TCSC_ACT_TOGGLE = 2'h3;

	// AXI response codes
	localparam logic [1:0] TCSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TCSC_RESP_DECERR = 2'h3;

	// Write-side states of the bus slave
	typedef enum logic [2:0] {
		TCSC_WR_IDLE = 3'b001,
		TCSC_WR_COLLECT = 3'b010,
		TCSC_WR_RESP = 3'b100
	} tcsc_wr_state_t;

endpackage : tcsc_pkg

/* design/tcsc_channel.sv */
// One timer channel: match flags, wrap flag, output pin action and clear sequence
`timescale 1ns/1ps

module tcsc_channel
	import tcsc_pkg::*;
#(
	parameter bit HAS_ADC_TRIGGER_ENABLE = 1'b1,
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Counter side
	input wire logic count_tick,
	input wire logic [CW-1:0] timer_count,
	input wire logic [CW-1:0] compare_const_a,
	input wire logic [CW-1:0] compare_const_b,
	// Software access
	input wire logic sw_read,
	input wire logic sw_write,
	input wire logic [7:0] sw_wdata,
	// Transfer controller
	input wire logic xfer_act_a,
	input wire logic xfer_act_b,
	input wire logic irq_disable_select,
	// Interrupt enables from the control register
	input wire logic match_a_irq_enable,
	input wire logic match_b_irq_enable,
	// Results
	output logic [7:0] status_byte,
	output logic match_a_strobe,
	output logic match_b_strobe,
	output logic wrap_strobe,
	output logic match_a_irq,
	output logic match_b_irq,
	output logic timer_output_pin,
	output logic adc_start
);

	// Higher code wins when both matches land together
	function automatic logic [1:0] pick_action(input logic [1:0] act_a, input logic [1:0] act_b);
		pick_action = (act_a > act_b) ? act_a : act_b;
	endfunction : pick_action

	logic [2:0] flags_reg, flags_next;
	logic [2:0] armed_reg, armed_next;
	logic adc_trigger_enable_reg, adc_trigger_enable_next;
	logic [1:0] osel_b_reg, osel_b_next;
	logic [1:0] osel_a_reg, osel_a_next;
	logic pin_reg, pin_next;
	logic adc_start_reg;
	wire logic [2:0] set_vec;
	wire logic [2:0] wr_zero;
	wire logic [2:0] clr_vec;
	wire logic [1:0] act_a;
	wire logic [1:0] act_b;
	wire logic [1:0] act_win;
	wire logic [CW-1:0] count_max;

	////////////////////////////////////////////////////////////////////////////////

	// Match strobes fire in the last cycle of the match, as the counter moves on
	assign count_max = TCSC_COUNT_MAX[CW-1:0];
	assign match_a_strobe = count_tick && (timer_count == compare_const_a); // R13
	assign match_b_strobe = count_tick && (timer_count == compare_const_b); // R13
	assign wrap_strobe = count_tick && (timer_count == count_max); // R3

	// Hardware set vector
	assign set_vec[TCSC_F_B] = match_b_strobe; // R1
	assign set_vec[TCSC_F_A] = match_a_strobe; // R2
	assign set_vec[TCSC_F_WRAP] = wrap_strobe; // R3

	// A written 0 clears only a flag that was read as 1 before; a written 1 does nothing
	assign wr_zero[TCSC_F_B] = sw_write && !sw_wdata[TCSC_BIT_MATCH_B]; // R5
	assign wr_zero[TCSC_F_A] = sw_write && !sw_wdata[TCSC_BIT_MATCH_A]; // R5
	assign wr_zero[TCSC_F_WRAP] = sw_write && !sw_wdata[TCSC_BIT_WRAP]; // R5
	assign clr_vec[TCSC_F_B] = (wr_zero[TCSC_F_B] && armed_reg[TCSC_F_B])
		|| (xfer_act_b && !irq_disable_select); // R4 R6
	assign clr_vec[TCSC_F_A] = (wr_zero[TCSC_F_A] && armed_reg[TCSC_F_A])
		|| (xfer_act_a && !irq_disable_select); // R4 R7
	assign clr_vec[TCSC_F_WRAP] = wr_zero[TCSC_F_WRAP] && armed_reg[TCSC_F_WRAP]; // R4

	// Set wins over clear so an event in the clearing cycle is kept
	assign flags_next = set_vec | (flags_reg & ~clr_vec); // R1 R2 R3 R4

	// A read arms each flag seen at 1 and wins over a write in the same cycle; any other write consumes the arming
	assign armed_next = sw_read ? flags_reg : (sw_write ? TCSC_FLAGS_RST : armed_reg); // R4

	// Control fields
	assign adc_trigger_enable_next = (HAS_ADC_TRIGGER_ENABLE && sw_write) ? sw_wdata[TCSC_BIT_ADC_TRIGGER_ENABLE]
		: adc_trigger_enable_reg; // R8 R11
	assign osel_b_next = sw_write ? sw_wdata[TCSC_OSB_HI:TCSC_OSB_LO] : osel_b_reg;
	assign osel_a_next = sw_write ? sw_wdata[TCSC_OSA_HI:TCSC_OSA_LO] : osel_a_reg;

	// Pin action per match, then priority toggle, 1, 0, keep
	assign act_b = match_b_strobe ? osel_b_reg : TCSC_ACT_KEEP; // R9
	assign act_a = match_a_strobe ? osel_a_reg : TCSC_ACT_KEEP; // R10
	assign act_win = pick_action(act_a, act_b); // R16
	assign pin_next = (act_win == TCSC_ACT_TOGGLE) ? !pin_reg
		: (act_win == TCSC_ACT_DRIVE1) ? 1'b1
		: (act_win == TCSC_ACT_DRIVE0) ? 1'b0 : pin_reg; // R9 R10 R16

	// Flag, arming and control state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= TCSC_FLAGS_RST; // R12
			armed_reg <= TCSC_FLAGS_RST;
			adc_trigger_enable_reg <= TCSC_ADC_TRIGGER_ENABLE_RST; // R12
			osel_b_reg <= TCSC_OSEL_RST; // R12
			osel_a_reg <= TCSC_OSEL_RST; // R12
			pin_reg <= TCSC_PIN_RST;
			adc_start_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			armed_reg <= armed_next;
			adc_trigger_enable_reg <= adc_trigger_enable_next;
			osel_b_reg <= osel_b_next;
			osel_a_reg <= osel_a_next;
			pin_reg <= pin_next;
			adc_start_reg <= HAS_ADC_TRIGGER_ENABLE && adc_trigger_enable_reg && match_a_strobe; // R8 R15
		end
	end

	// Read view; the reserved bit of a channel without trigger enable reads 1
	assign status_byte = {flags_reg[TCSC_F_B], flags_reg[TCSC_F_A], flags_reg[TCSC_F_WRAP],
		(HAS_ADC_TRIGGER_ENABLE ? adc_trigger_enable_reg : TCSC_RSVD_READ), osel_b_reg, osel_a_reg}; // R11

	// Requests follow the flags; the controller clears them by activation
	assign match_a_irq = flags_reg[TCSC_F_A] && match_a_irq_enable; // R14
	assign match_b_irq = flags_reg[TCSC_F_B] && match_b_irq_enable;
	assign timer_output_pin = pin_reg;
	assign adc_start = adc_start_reg; // R15

endmodule : tcsc_channel

/* design/tcsc_top.sv */
// Two-channel timer compare status and control registers behind an AXI4-Lite slave
//
// Summary of operation
// R1: A compare-B match of the counter sets the compare-B flag at status bit 7.
// R2: A compare-A match of the counter sets the compare-A flag at status bit 6.
// R3: A counter wrap from its maximum value to zero sets the wrap flag at bit 5.
// R4: Software clears a flag only by first reading it at 1 and then writing 0 to it.
// R5: Writes to bits 7 to 5 act only as clears by 0; a written 1 leaves the flag alone.
// R6: A transfer-controller start by request B clears flag B while its disable select is 0.
// R7: A transfer-controller start by request A clears flag A while its disable select is 0.
// R8: On channel 0, bit 4 at 1 lets compare-A request an A/D start; at 0 it blocks it.
// R9: Bits 3:2 pick the pin action on match B: keep, drive 0, drive 1 or toggle.
// R10: Bits 1:0 pick the pin action on match A: keep, drive 0, drive 1 or toggle.
// R11: On channel 1, bit 4 is reserved, always reads 1 and ignores writes.
// R12: Reset clears all flags, the A/D trigger enable and all output selects.
// R13: A match strobe fires in the last cycle of the match, just before the counter moves.
// R14: The compare-A request rises only while the A flag and its enable are both 1.
// R15: A compare-A flag set while the trigger enable is 1 sends an A/D start request.
// R16: When both matches land together the pin takes toggle, then 1, then 0, then keep.
`timescale 1ns/1ps

module tcsc_top
	import tcsc_pkg::*;
#(
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,

	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,

	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,

	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,

	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,

	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,

	// Channel 0 counter side
	input wire logic ch0_count_tick,
	input wire logic [CW-1:0] ch0_timer_count,
	input wire logic [CW-1:0] ch0_compare_const_a,
	input wire logic [CW-1:0] ch0_compare_const_b,

	// Channel 1 counter side
	input wire logic ch1_count_tick,
	input wire logic [CW-1:0] ch1_timer_count,
	input wire logic [CW-1:0] ch1_compare_const_a,
	input wire logic [CW-1:0] ch1_compare_const_b,

	// Interrupt enables from the timer control registers
	input wire logic ch0_match_a_irq_enable,
	input wire logic ch0_match_b_irq_enable,
	input wire logic ch1_match_a_irq_enable,
	input wire logic ch1_match_b_irq_enable,

	// Transfer controller activations
	input wire logic ch0_xfer_act_a,
	input wire logic ch0_xfer_act_b,
	input wire logic ch1_xfer_act_a,
	input wire logic ch1_xfer_act_b,
	input wire logic irq_disable_select,

	// Match and wrap strobes to the rest of the timer
	output logic ch0_match_a_strobe,
	output logic ch0_match_b_strobe,
	output logic ch0_wrap_strobe,
	output logic ch1_match_a_strobe,
	output logic ch1_match_b_strobe,
	output logic ch1_wrap_strobe,

	// Interrupt requests
	output logic ch0_match_a_irq,
	output logic ch0_match_b_irq,
	output logic ch1_match_a_irq,
	output logic ch1_match_b_irq,

	// Timer output pins and converter start
	output logic ch0_timer_output_pin,
	output logic ch1_timer_output_pin,
	output logic adc_start
);

	// Byte-address decode helper, used by both the read and write paths
	function automatic logic [2:0] decode_addr(
		input logic [31:0] addr);
		logic [TCSC_ADDR_W-1:0] byte_addr;
		byte_addr = addr[TCSC_ADDR_W-1:0];
		decode_addr = 3'h0;
		// High bits must be zero
		if (addr[31:TCSC_ADDR_W] == '0) begin
			decode_addr[0] = (byte_addr == TCSC_ADDR_CH0);
			decode_addr[1] = (byte_addr == TCSC_ADDR_CH1);
			decode_addr[2] = (byte_addr == TCSC_ADDR_PINS);
		end
	endfunction : decode_addr

	////////////////////////////////////////////////////////////////////////////////
	// Write channel

	// Write path state
	tcsc_wr_state_t wr_state_reg, wr_state_next;
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [31:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic [1:0] bresp_reg, bresp_next;
	wire logic aw_take;
	wire logic w_take;
	wire logic wr_fire;
	wire logic [2:0] wr_sel;
	wire logic ch0_write;
	wire logic ch1_write;

	// Address and data are taken in either order; no new write until the response leaves
	assign s_axi_awready = !aw_held_reg
		&& (wr_state_reg != TCSC_WR_RESP);
	assign s_axi_wready = !w_held_reg
		&& (wr_state_reg != TCSC_WR_RESP);
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;

	// Holding registers take the live beat when it arrives this cycle
	assign aw_held_next = (wr_fire || (wr_state_reg == TCSC_WR_RESP)) ? 1'b0
		: (aw_held_reg || aw_take);
	assign w_held_next = (wr_fire || (wr_state_reg == TCSC_WR_RESP)) ? 1'b0
		: (w_held_reg || w_take);
	assign awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
	assign wdata_next = w_take ? s_axi_wdata : wdata_reg;
	assign wstrb0_next = w_take ? s_axi_wstrb[0] : wstrb0_reg;

	// The write lands in the cycle after both halves are held
	assign wr_fire = (wr_state_reg == TCSC_WR_COLLECT)
		&& aw_held_reg && w_held_reg;
	assign wr_sel = decode_addr(awaddr_reg);
	assign ch0_write = wr_fire && wr_sel[0] && wstrb0_reg;
	assign ch1_write = wr_fire && wr_sel[1] && wstrb0_reg;
	assign bresp_next = wr_fire ? ((wr_sel != 3'h0) ? TCSC_RESP_OKAY : TCSC_RESP_DECERR)
		: bresp_reg;

	// Write sequencing
	always_comb begin
		// Hold by default
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			TCSC_WR_IDLE: begin
				// Either half may come first
				if (aw_take || w_take) begin
					wr_state_next = TCSC_WR_COLLECT;
				end
			end

			TCSC_WR_COLLECT: begin
				// Both halves held
				if (wr_fire) begin
					wr_state_next = TCSC_WR_RESP;
				end
			end

			TCSC_WR_RESP: begin
				// A slow bready stalls writes
				if (s_axi_bready) begin
					wr_state_next = TCSC_WR_IDLE;
				end
			end

			default: begin
				// Illegal code back to idle
				wr_state_next = TCSC_WR_IDLE;
			end
		endcase
	end

	// Write-side registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= TCSC_WR_IDLE;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 32'h0000_0000;
			wdata_reg <= 32'h0000_0000;
			wstrb0_reg <= 1'b0;
			bresp_reg <= TCSC_RESP_OKAY;
		end else begin
			wr_state_reg <= wr_state_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bresp_reg <= bresp_next;
		end
	end

	// Response outputs
	assign s_axi_bvalid = (wr_state_reg == TCSC_WR_RESP);
	assign s_axi_bresp = bresp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read channel

	// Read path state
	logic rvalid_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	wire logic ar_take;
	wire logic [2:0] rd_sel;
	wire logic ch0_read;
	wire logic ch1_read;
	wire logic [7:0] ch0_status;
	wire logic [7:0] ch1_status;
	wire logic [31:0] rd_word;

	// One read at a time; the data is captured at the address handshake
	assign s_axi_arready = !rvalid_reg;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	// Address is steady while arvalid waits
	assign rd_sel = decode_addr(s_axi_araddr);

	// Reading a status register arms its set flags for a later clear
	assign ch0_read = ar_take && rd_sel[0]; // R4
	assign ch1_read = ar_take && rd_sel[1]; // R4

	// Unmapped reads return zero with a decode error
	assign rd_word = rd_sel[0] ? {24'h00_0000, ch0_status}
		: rd_sel[1] ? {24'h00_0000, ch1_status}
		: rd_sel[2] ? {30'h0000_0000, ch1_timer_output_pin, ch0_timer_output_pin}
		: 32'h0000_0000;
	assign rdata_next = ar_take ? rd_word : rdata_reg;
	assign rresp_next = ar_take ? ((rd_sel != 3'h0) ? TCSC_RESP_OKAY : TCSC_RESP_DECERR)
		: rresp_reg;

	// Read-side registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= TCSC_RESP_OKAY;
		end else begin
			rvalid_reg <= ar_take
				|| (rvalid_reg && !s_axi_rready);
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Read outputs
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Channels

	// Converter start net
	wire logic ch0_adc_start;

	// Channel 0 owns the converter trigger enable
	tcsc_channel #(
		.HAS_ADC_TRIGGER_ENABLE(1'b1),
		.CW(CW)
	) u_ch0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_tick(ch0_count_tick),
		.timer_count(ch0_timer_count),
		.compare_const_a(ch0_compare_const_a),
		.compare_const_b(ch0_compare_const_b),
		.sw_read(ch0_read),
		.sw_write(ch0_write),
		.sw_wdata(wdata_reg[7:0]),
		.xfer_act_a(ch0_xfer_act_a),
		.xfer_act_b(ch0_xfer_act_b),
		.irq_disable_select(irq_disable_select),
		.match_a_irq_enable(ch0_match_a_irq_enable),
		.match_b_irq_enable(ch0_match_b_irq_enable),
		.status_byte(ch0_status),
		.match_a_strobe(ch0_match_a_strobe),
		.match_b_strobe(ch0_match_b_strobe),
		.wrap_strobe(ch0_wrap_strobe),
		.match_a_irq(ch0_match_a_irq),
		.match_b_irq(ch0_match_b_irq),
		.timer_output_pin(ch0_timer_output_pin),
		.adc_start(ch0_adc_start)
	); // R8 R15

	// Channel 1 has a reserved bit 4 in place of the trigger enable
	tcsc_channel #(
		.HAS_ADC_TRIGGER_ENABLE(1'b0),
		.CW(CW)
	) u_ch1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_tick(ch1_count_tick),
		.timer_count(ch1_timer_count),
		.compare_const_a(ch1_compare_const_a),
		.compare_const_b(ch1_compare_const_b),
		.sw_read(ch1_read),
		.sw_write(ch1_write),
		.sw_wdata(wdata_reg[7:0]),
		.xfer_act_a(ch1_xfer_act_a),
		.xfer_act_b(ch1_xfer_act_b),
		.irq_disable_select(irq_disable_select),
		.match_a_irq_enable(ch1_match_a_irq_enable),
		.match_b_irq_enable(ch1_match_b_irq_enable),
		.status_byte(ch1_status),
		.match_a_strobe(ch1_match_a_strobe),
		.match_b_strobe(ch1_match_b_strobe),
		.wrap_strobe(ch1_wrap_strobe),
		.match_a_irq(ch1_match_a_irq),
		.match_b_irq(ch1_match_b_irq),
		.timer_output_pin(ch1_timer_output_pin),
		.adc_start()
	); // R11

	// Only channel 0 may start the converter
	assign adc_start = ch0_adc_start; // R15

endmodule : tcsc_top

/* test/tcsc_top_properties.sv */
// Concurrent checks on the ports of the timer compare status and control block
`timescale 1ns/1ps

module tcsc_top_checker
	import tcsc_pkg::*;
#(
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Channel 0 counter side
	input wire logic ch0_count_tick,
	input wire logic [CW-1:0] ch0_timer_count,
	input wire logic [CW-1:0] ch0_compare_const_a,
	input wire logic ch0_match_a_irq_enable,
	input wire logic ch0_xfer_act_a,
	input wire logic irq_disable_select,
	// Channel 0 results
	input wire logic ch0_match_a_strobe,
	input wire logic ch0_match_b_strobe,
	input wire logic ch0_wrap_strobe,
	input wire logic ch0_match_a_irq,
	input wire logic ch0_timer_output_pin,
	input wire logic adc_start,
	// Channel 1 compare B
	input wire logic ch1_match_b_strobe,
	input wire logic ch1_match_b_irq_enable,
	input wire logic ch1_match_b_irq
);

////////////////////////////////////////////////////////////////////////////////
	// One clock domain, so clocking and reset are given once
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_MATCH_A_STROBE: assert property (ch0_match_a_strobe ==
		(ch0_count_tick && ch0_timer_count == ch0_compare_const_a))
		else $error("match A strobe does not follow tick and equality");
	AST_FLAG_A_REQ: assert property (ch0_match_a_strobe && ch0_match_a_irq_enable ##1
		ch0_match_a_irq_enable |-> ch0_match_a_irq)
		else $error("match A did not raise its request");
	AST_REQ_NEEDS_ENABLE: assert property (!ch0_match_a_irq_enable |-> !ch0_match_a_irq)
		else $error("match A request without its enable");
	AST_FLAG_B_REQ: assert property (ch1_match_b_strobe && ch1_match_b_irq_enable ##1
		ch1_match_b_irq_enable |-> ch1_match_b_irq)
		else $error("match B did not raise its request");
	AST_WRAP_STROBE: assert property (ch0_wrap_strobe ==
		(ch0_count_tick && ch0_timer_count == TCSC_COUNT_MAX))
		else $error("wrap strobe does not follow a tick at the top count");
	AST_ADC_CAUSE: assert property (adc_start |-> $past(ch0_match_a_strobe))
		else $error("converter start without a preceding match A");
	// Set beats clear, so a match in the same cycle is excluded
	AST_ACT_CLEARS_A: assert property (ch0_xfer_act_a && !irq_disable_select &&
		!ch0_match_a_strobe && ch0_match_a_irq_enable ##1 ch0_match_a_irq_enable
		|-> !ch0_match_a_irq)
		else $error("transfer activation left match A flag set");
	AST_PIN_HOLDS: assert property (!ch0_match_a_strobe && !ch0_match_b_strobe
		|=> $stable(ch0_timer_output_pin))
		else $error("output pin moved without a match");

	// Main scenarios
	COV_ADC: cover property (adc_start);
	COV_BOTH: cover property (ch0_match_a_strobe && ch0_match_b_strobe);
	COV_ACT: cover property (ch0_xfer_act_a && !irq_disable_select && ch0_match_a_irq);

endmodule : tcsc_top_checker

bind tcsc_top tcsc_top_checker #(.CW(CW)) u_checker (.*);

/* test/tcsc_top_test.sv */
// Self-checking bench for the timer compare status and control block
`timescale 1ns/1ps

module tcsc_top_test
	import tcsc_pkg::*;
;
	logic aclk, aresetn;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic ch0_count_tick, ch1_count_tick, irq_disable_select, adc_start;
	logic [7:0] ch0_timer_count, ch0_compare_const_a, ch0_compare_const_b;
	logic [7:0] ch1_timer_count, ch1_compare_const_a, ch1_compare_const_b;
	logic ch0_match_a_irq_enable, ch0_match_b_irq_enable;
	logic ch1_match_a_irq_enable, ch1_match_b_irq_enable;
	logic ch0_xfer_act_a, ch0_xfer_act_b, ch1_xfer_act_a, ch1_xfer_act_b;
	logic ch0_match_a_strobe, ch0_match_b_strobe, ch0_wrap_strobe;
	logic ch1_match_a_strobe, ch1_match_b_strobe, ch1_wrap_strobe;
	logic ch0_match_a_irq, ch0_match_b_irq, ch1_match_a_irq, ch1_match_b_irq;
	logic ch0_timer_output_pin, ch1_timer_output_pin;
	int n_fail, tests_run, cyc;
	logic pin_exp;
	// Pin cases: [5:4] 0 match A, 1 match B, 2 both; [3:2] B select; [1:0] A select
	localparam logic [5:0] PIN_CASES [12] = '{6'h02, 6'h00, 6'h01, 6'h03, 6'h14, 6'h18,
		6'h1C, 6'h10, 6'h26, 6'h2D, 6'h28, 6'h2B};

	tcsc_top #(.CW(8)) u_dut (.*);

////////////////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Hang guard, far above the run's length
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end

	task end_sim;
		$display("Comparisons: %0d, mismatches: %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task chk_bit(input string what, input logic exp, input logic got);
		chk_byte(what, {7'h0, exp}, {7'h0, got});
	endtask : chk_bit

////////////////////////////////////////////////////////////////////////////////
	// Bus cycles: each handshake is judged and released at the rising edge it lands on
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] eresp);
		bit aw, w, b;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			if (b) chk_byte("bresp", {6'h0, eresp}, {6'h0, s_axi_bresp});
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] eresp);
		bit ar, r;
		r = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r) begin
			@(posedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			if (r) chk_byte("rdata", exp, s_axi_rdata[7:0]);
			if (r) chk_byte("rresp", {6'h0, eresp}, {6'h0, s_axi_rresp});
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
	endtask : rd_chk

	// One counting cycle at the given count; results are settled on return
	task tick(input bit ch, input logic [7:0] c);
		@(posedge aclk);
		if (ch) begin
			ch1_count_tick <= 1'b1;
			ch1_timer_count <= c;
		end else begin
			ch0_count_tick <= 1'b1;
			ch0_timer_count <= c;
		end
		@(posedge aclk);
		ch0_count_tick <= 1'b0;
		ch1_count_tick <= 1'b0;
		#1;
	endtask : tick

	task act_pulse(input bit ch);
		@(posedge aclk);
		{ch1_xfer_act_a, ch1_xfer_act_b} <= {2{ch}};
		{ch0_xfer_act_a, ch0_xfer_act_b} <= {2{~ch}};
		@(posedge aclk);
		{ch0_xfer_act_a, ch0_xfer_act_b, ch1_xfer_act_a, ch1_xfer_act_b} <= 4'h0;
		#1;
	endtask : act_pulse

////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd_chk(TCSC_ADDR_CH0, 8'h00, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH1, 8'h10, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_PINS, 8'h00, TCSC_RESP_OKAY);
		wr(TCSC_ADDR_CH0, 8'hE0, TCSC_RESP_OKAY);
		wr(TCSC_ADDR_CH1, 8'h00, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH0, 8'h00, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH1, 8'h10, TCSC_RESP_OKAY);
	endtask : t_reset

	// Every select code on each match alone and every A select code in contention, tracked from a known pin
	task t_pins;
		logic [1:0] md, code;
		pin_exp = 1'b0;
		for (int i = 0; i < 12; i++) begin
			md = PIN_CASES[i][5:4];
			wr(TCSC_ADDR_CH0, {4'h0, PIN_CASES[i][3:0]}, TCSC_RESP_OKAY);
			code = (md == 2'h1) ? 2'h0 : PIN_CASES[i][1:0];
			if (md != 2'h0 && PIN_CASES[i][3:2] > code) code = PIN_CASES[i][3:2];
			if (code == TCSC_ACT_DRIVE0) pin_exp = 1'b0;
			if (code == TCSC_ACT_DRIVE1) pin_exp = 1'b1;
			if (code == TCSC_ACT_TOGGLE) pin_exp = ~pin_exp;
			ch0_compare_const_b <= (md == 2'h2) ? 8'h10 : 8'h20;
			tick(1'b0, (md == 2'h1) ? 8'h20 : 8'h10);
			chk_bit("ch0 pin", pin_exp, ch0_timer_output_pin);
		end
		ch0_compare_const_b <= 8'h20;
	endtask : t_pins

	task t_match_a;
		rd_chk(TCSC_ADDR_CH0, 8'hCB, TCSC_RESP_OKAY);
		chk_bit("ch0 irq b", 1'b1, ch0_match_b_irq);
		wr(TCSC_ADDR_CH0, 8'h13, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH0, 8'h13, TCSC_RESP_OKAY);
		tick(1'b0, 8'h10);
		chk_bit("adc start", 1'b1, adc_start);
		chk_bit("ch0 irq a", 1'b1, ch0_match_a_irq);
		chk_bit("ch0 pin", 1'b1, ch0_timer_output_pin);
		{ch0_match_a_irq_enable, ch0_match_b_irq_enable} <= 2'b00;
		#1;
		chk_bit("ch0 irq a", 1'b0, ch0_match_a_irq);
		{ch0_match_a_irq_enable, ch0_match_b_irq_enable} <= 2'b11;
		// A write with no read of the flag at 1 must not clear it
		wr(TCSC_ADDR_CH0, 8'h03, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH0, 8'h43, TCSC_RESP_OKAY);
		irq_disable_select <= 1'b1;
		act_pulse(1'b0);
		chk_bit("ch0 irq a", 1'b1, ch0_match_a_irq);
		irq_disable_select <= 1'b0;
		act_pulse(1'b0);
		chk_bit("ch0 irq a", 1'b0, ch0_match_a_irq);
		tick(1'b0, 8'h10);
		chk_bit("adc start", 1'b0, adc_start);
		tick(1'b0, 8'hFF);
		rd_chk(TCSC_ADDR_CH0, 8'h63, TCSC_RESP_OKAY);
	endtask : t_match_a

	task t_ch1;
		tick(1'b1, 8'h40);
		chk_bit("ch1 irq b", 1'b1, ch1_match_b_irq);
		tick(1'b1, 8'h30);
		chk_bit("ch1 irq a", 1'b1, ch1_match_a_irq);
		tick(1'b1, 8'hFF);
		rd_chk(TCSC_ADDR_CH1, 8'hF0, TCSC_RESP_OKAY);
		act_pulse(1'b1);
		chk_bit("ch1 irq b", 1'b0, ch1_match_b_irq);
		wr(TCSC_ADDR_CH1, 8'h00, TCSC_RESP_OKAY);
		rd_chk(TCSC_ADDR_CH1, 8'h10, TCSC_RESP_OKAY);
		wr(8'h0C, 8'hFF, TCSC_RESP_DECERR);
		rd_chk(8'h0C, 8'h00, TCSC_RESP_DECERR);
	endtask : t_ch1

////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{aresetn, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ch0_count_tick, ch1_count_tick, irq_disable_select, ch0_timer_count} = '0;
		{ch1_timer_count, ch0_xfer_act_a, ch0_xfer_act_b, ch1_xfer_act_a, ch1_xfer_act_b} = '0;
		{ch0_match_a_irq_enable, ch0_match_b_irq_enable} = 2'b11;
		{ch1_match_a_irq_enable, ch1_match_b_irq_enable} = 2'b11;
		s_axi_wstrb = 4'hF;
		ch0_compare_const_a = 8'h10;
		ch0_compare_const_b = 8'h20;
		ch1_compare_const_a = 8'h30;
		ch1_compare_const_b = 8'h40;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_pins;
		t_match_a;
		t_ch1;
		end_sim;
	end

endmodule : tcsc_top_test
